// file: core/map_paging_pkg.sv
package map_paging_pkg;

    // main map write addresses, one per level of the address select pin
    localparam logic [7:0] MAIN_WR_ADDR_LOW  = 8'h40;
    localparam logic [7:0] MAIN_WR_ADDR_HIGH = 8'h42;

    // own registers and their offsets
    localparam logic [7:0] PAGE_SELECT_OFF   = 8'h0e;
    localparam logic [7:0] POSTPROC_ADDR_OFF = 8'hfd;
    localparam logic [7:0] CAMERA_ADDR_OFF   = 8'hfe;
    localparam logic [7:0] PAGE_SELECT_RST   = 8'h00;
    localparam logic [7:0] POSTPROC_ADDR_RST = 8'h00;
    localparam logic [7:0] CAMERA_ADDR_RST   = 8'h00;
    localparam int         PAGE_FIELD_LSB    = 5;
    localparam int         PAGE_FIELD_MSB    = 6;

    // page field codes
    localparam logic [1:0] PAGE_USER  = 2'h0;
    localparam logic [1:0] PAGE_INTR  = 2'h1;
    localparam logic [1:0] PAGE_USER2 = 2'h2;

    // highest subaddress; auto-increment holds here
    localparam logic [7:0] SUBADDR_MAX   = 8'hff;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        MAP_NONE,
        MAP_USER,
        MAP_INTR,
        MAP_USER2,
        MAP_POSTPROC,
        MAP_CAMERA
    } map_e;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_SUB,
        ST_SUB_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } bus_state_e;

    // register access towards the map contents
    typedef struct packed {
        logic       writeStrobe;
        logic       readStrobe;
        map_e       map;
        logic [7:0] subaddr;
        logic [7:0] wdata;
    } reg_access_s;

endpackage : map_paging_pkg

// file: core/register_map_paging_decoder.sv
// How it works
// [R1] main map answers at 0x40/0x41 with select pin low, 0x42/0x43 high.
// [R2] page field 0x0E[6:5] routes main accesses: 00 user, 01 intr, 10 user2.
// [R3] all sub maps share the main address; only the page field selects.
// [R4] page field resets to the user sub map.
// [R5] host writes the page field back to user when done with other pages.
// [R6] post-processor address lives in 0xFD[7:1], resets to 0, dead while 0.
// [R7] host is advised to program the post-processor map to 0x84/0x85.
// [R8] camera-link address lives in 0xFE[7:1], resets to 0, dead while 0.
// [R9] host is advised to program the camera-link map to 0x88/0x89.
// [R10] programmed maps decode on their own address only, pin/page ignored.
// [R11] camera-link map exists only in the serial camera output variant.
// [R12] subaddress increments after each data byte, the first one included; the code holds it at 0xFF instead.
// [R13] invalid subaddress gets no acknowledge and the device goes idle.
// [R14] new page or map address takes effect from the next transaction.
`timescale 1ns/1ps
module register_map_paging_decoder #(
    parameter bit CAMERA_LINK_PRESENT = 1'b1
) (
    input  wire logic                        mclk,
    input  wire logic                        nrst,
    input  wire logic                        sclIn,
    input  wire logic                        sdaIn,
    output logic                             sdaOut,
    output logic                             sdaOe,
    input  wire logic                        address_select_pin,
    output map_paging_pkg::reg_access_s      regAccess,
    input  wire logic [7:0]                  regRdata,
    input  wire logic                        subaddrKnown,
    output logic [1:0]                       sub_map_page_field,
    output logic [7:0]                       postprocAddr,
    output logic [7:0]                       cameraAddr
);
    import map_paging_pkg::*;

    // two-stage synchronisers, third stage only for edge detection
    logic [2:0] sclSync_reg;
    logic [2:0] sdaSync_reg;
    logic [1:0] selSync_reg;

    logic [7:0]  pageSelect_reg;
    logic [7:0]  postprocAddr_reg;
    logic [7:0]  cameraAddr_reg;
    bus_state_e  state_reg;
    map_e        map_reg;
    logic        readMode_reg;
    logic [3:0]  bitCnt_reg;
    logic [7:0]  rxShift_reg;
    logic [7:0]  txShift_reg;
    logic [7:0]  subaddr_reg;
    logic        sdaOe_reg;
    logic        wrStrobe_reg;
    logic        rdStrobe_reg;
    logic [7:0]  wdata_reg;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sclSync_reg <= 3'h7;
            sdaSync_reg <= 3'h7;
            selSync_reg <= 2'h0;
        end else begin
            sclSync_reg <= {sclSync_reg[1:0], sclIn};
            sdaSync_reg <= {sdaSync_reg[1:0], sdaIn};
            selSync_reg <= {selSync_reg[0], address_select_pin};
        end
    end

    wire sclHigh  = sclSync_reg[1];
    wire sdaBit   = sdaSync_reg[1];
    wire sclRise  = sclSync_reg[1] & ~sclSync_reg[2];
    wire sclFall  = ~sclSync_reg[1] & sclSync_reg[2];
    wire startCnd = sclHigh & sclSync_reg[2] & ~sdaSync_reg[1]
                    & sdaSync_reg[2];
    wire stopCnd  = sclHigh & sclSync_reg[2] & sdaSync_reg[1]
                    & ~sdaSync_reg[2];
    wire byteDone = (bitCnt_reg == BITS_PER_BYTE);

    // address decode against the values held before this transaction
    wire [7:0] mainWrAddr  = selSync_reg[1] ? MAIN_WR_ADDR_HIGH
                                            : MAIN_WR_ADDR_LOW;  // see [R1]
    wire [1:0] pageField   = pageSelect_reg[PAGE_FIELD_MSB:PAGE_FIELD_LSB];
    wire       mainHit     = (rxShift_reg[7:1] == mainWrAddr[7:1]); // see [R1]
    wire       postprocHit = (postprocAddr_reg[7:1] != 7'h00)
                             && (rxShift_reg[7:1] == postprocAddr_reg[7:1]);
                             // see [R6] [R10]
    wire       cameraHit   = CAMERA_LINK_PRESENT
                             && (cameraAddr_reg[7:1] != 7'h00)
                             && (rxShift_reg[7:1] == cameraAddr_reg[7:1]);
                             // see [R8] [R10] [R11]
    // page 11 is unassigned; it falls back to the user map so the
    // host can always reach the page register again
    wire map_e pageMap = (pageField == PAGE_INTR)  ? MAP_INTR :
                         (pageField == PAGE_USER2) ? MAP_USER2 :
                                                     MAP_USER; // see [R2] [R3]
    wire map_e addrMap = mainHit     ? pageMap :
                         postprocHit ? MAP_POSTPROC :
                         cameraHit   ? MAP_CAMERA : MAP_NONE;

    // own registers; the page register is visible from every main page
    function automatic logic ownSub(input map_e m, input logic [7:0] s);
        logic isMain;
        isMain = (m == MAP_USER) || (m == MAP_INTR) || (m == MAP_USER2);
        ownSub = (isMain && s == PAGE_SELECT_OFF)
                 || (m == MAP_USER && s == POSTPROC_ADDR_OFF)
                 || (m == MAP_USER && s == CAMERA_ADDR_OFF
                     && CAMERA_LINK_PRESENT);
    endfunction : ownSub

    wire subRxValid  = ownSub(map_reg, rxShift_reg) || subaddrKnown;
    wire subCurValid = ownSub(map_reg, subaddr_reg) || subaddrKnown;
    wire ownPage     = ownSub(map_reg, subaddr_reg)
                       && subaddr_reg == PAGE_SELECT_OFF;
    wire ownPost     = ownSub(map_reg, subaddr_reg)
                       && subaddr_reg == POSTPROC_ADDR_OFF;
    wire ownCam      = ownSub(map_reg, subaddr_reg)
                       && subaddr_reg == CAMERA_ADDR_OFF;
    wire [7:0] readByte = ownPage ? pageSelect_reg :
                          ownPost ? postprocAddr_reg :
                          ownCam  ? cameraAddr_reg : regRdata;
    // hold at the top subaddress instead of wrapping
    wire [7:0] subNext  = (subaddr_reg == SUBADDR_MAX) ? SUBADDR_MAX
                          : subaddr_reg + 8'h01; // see [R12]
    wire ownWrite = (state_reg == ST_WDATA) && sclFall && byteDone
                    && subCurValid;

    // map writes land between bytes; map_reg was latched at the address
    // byte, so nothing changes until the next start
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pageSelect_reg   <= PAGE_SELECT_RST;   // see [R4]
            postprocAddr_reg <= POSTPROC_ADDR_RST; // see [R6]
            cameraAddr_reg   <= CAMERA_ADDR_RST;   // see [R8]
        end else if (ownWrite) begin
            if (ownPage) pageSelect_reg <= rxShift_reg; // see [R2] [R14]
            if (ownPost) postprocAddr_reg <= rxShift_reg; // see [R6]
            if (ownCam) cameraAddr_reg <= rxShift_reg;   // see [R8]
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= ST_IDLE;
            map_reg      <= MAP_NONE;
            readMode_reg <= 1'b0;
            bitCnt_reg   <= 4'h0;
            rxShift_reg  <= 8'h00;
            txShift_reg  <= 8'h00;
            subaddr_reg  <= 8'h00;
            sdaOe_reg    <= 1'b0;
            wrStrobe_reg <= 1'b0;
            rdStrobe_reg <= 1'b0;
            wdata_reg    <= 8'h00;
        end else begin
            wrStrobe_reg <= 1'b0;
            rdStrobe_reg <= 1'b0;
            if (stopCnd) begin
                state_reg <= ST_IDLE;
                sdaOe_reg <= 1'b0;
            end else if (startCnd) begin
                state_reg  <= ST_ADDR;
                bitCnt_reg <= 4'h0;
                sdaOe_reg  <= 1'b0;
            end else begin
                unique case (state_reg)
                ST_IDLE: begin
                    sdaOe_reg <= 1'b0;
                end
                ST_ADDR, ST_SUB, ST_WDATA: begin
                    if (sclRise) begin
                        rxShift_reg <= {rxShift_reg[6:0], sdaBit};
                        bitCnt_reg  <= bitCnt_reg + 4'h1;
                    end else if (sclFall && byteDone) begin
                        sdaOe_reg <= 1'b1;
                        if (state_reg == ST_ADDR) begin
                            map_reg      <= addrMap; // see [R14]
                            readMode_reg <= rxShift_reg[0];
                            state_reg    <= ST_ADDR_ACK;
                            if (addrMap == MAP_NONE) begin
                                sdaOe_reg <= 1'b0;
                                state_reg <= ST_IDLE;
                            end
                        end else if (state_reg == ST_SUB) begin
                            subaddr_reg <= rxShift_reg; // see [R12]
                            state_reg   <= ST_SUB_ACK;
                            if (!subRxValid) begin
                                sdaOe_reg <= 1'b0; // see [R13]
                                state_reg <= ST_IDLE;
                            end
                        end else if (subCurValid) begin
                            wrStrobe_reg <= 1'b1;
                            wdata_reg    <= rxShift_reg;
                            state_reg    <= ST_WDATA_ACK;
                        end else begin
                            sdaOe_reg <= 1'b0; // see [R13]
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_SUB_ACK, ST_WDATA_ACK: begin
                    if (sclFall) begin
                        bitCnt_reg <= 4'h0;
                        sdaOe_reg  <= 1'b0;
                        if (state_reg == ST_WDATA_ACK) begin
                            subaddr_reg <= subNext; // see [R12]
                            state_reg   <= ST_WDATA;
                        end else if (state_reg == ST_SUB_ACK) begin
                            state_reg <= ST_WDATA;
                        end else if (readMode_reg) begin
                            txShift_reg  <= readByte;
                            sdaOe_reg    <= ~readByte[7];
                            rdStrobe_reg <= 1'b1;
                            state_reg    <= ST_RDATA;
                        end else begin
                            state_reg <= ST_SUB;
                        end
                    end
                end
                ST_RDATA: begin
                    if (sclRise) begin
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end else if (sclFall && byteDone) begin
                        sdaOe_reg   <= 1'b0;
                        subaddr_reg <= subNext; // see [R12]
                        state_reg   <= ST_RDATA_ACK;
                    end else if (sclFall) begin
                        txShift_reg <= {txShift_reg[6:0], 1'b0};
                        sdaOe_reg   <= ~txShift_reg[6];
                    end
                end
                ST_RDATA_ACK: begin
                    if (sclRise && sdaBit) begin
                        state_reg <= ST_IDLE;
                    end else if (sclFall) begin
                        bitCnt_reg   <= 4'h0;
                        txShift_reg  <= readByte;
                        sdaOe_reg    <= ~readByte[7];
                        rdStrobe_reg <= 1'b1;
                        state_reg    <= ST_RDATA;
                    end
                end
                endcase
            end
        end
    end

    // open drain: the line is only ever pulled low
    assign sdaOut                = 1'b0;
    assign sdaOe                 = sdaOe_reg;
    assign regAccess.writeStrobe = wrStrobe_reg;
    assign regAccess.readStrobe  = rdStrobe_reg;
    assign regAccess.map         = map_reg;
    assign regAccess.subaddr     = subaddr_reg;
    assign regAccess.wdata       = wdata_reg;
    assign sub_map_page_field    = pageField;
    assign postprocAddr          = postprocAddr_reg;
    assign cameraAddr            = cameraAddr_reg;

endmodule : register_map_paging_decoder

// file: testbench/map_paging_chk.sv
`timescale 1ns/1ps
module map_paging_chk (
    input wire logic                        mclk,
    input wire logic                        nrst,
    input wire map_paging_pkg::reg_access_s regAccess,
    input wire logic [1:0]                  sub_map_page_field,
    input wire logic [7:0]                  postprocAddr,
    input wire logic [7:0]                  cameraAddr
);
    import map_paging_pkg::*;
    wire logic       ws      = regAccess.writeStrobe;
    wire logic [7:0] sub     = regAccess.subaddr;
    wire logic       mainMap = regAccess.map inside {MAP_USER, MAP_INTR,
                                                     MAP_USER2};
    wire logic       userMap = regAccess.map == MAP_USER;
    wire logic       pageWr  = ws && mainMap && sub == PAGE_SELECT_OFF;
    wire logic       postWr  = ws && userMap && sub == POSTPROC_ADDR_OFF;
    wire logic       camWr   = ws && userMap && sub == CAMERA_ADDR_OFF;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    a_reset_defaults: assert property ($rose(nrst) |->
        sub_map_page_field == 2'h0 && postprocAddr == 8'h00
        && cameraAddr == 8'h00) else $error("bad values after reset");
    a_page_value: assert property (pageWr |-> ##[0:2]
        sub_map_page_field == regAccess.wdata[6:5]) else $error("page lost");
    a_page_only: assert property ($changed(sub_map_page_field) |->
        pageWr || $past(pageWr) || $past(pageWr, 2))
        else $error("page moved without a write");
    a_post_value: assert property (postWr |-> ##[0:2]
        postprocAddr == regAccess.wdata) else $error("postproc addr lost");
    a_cam_value: assert property (camWr |-> ##[0:2]
        cameraAddr == regAccess.wdata) else $error("camera addr lost");
    a_post_dead: assert property (
        ws && regAccess.map == MAP_POSTPROC |-> postprocAddr[7:1] != 7'h0)
        else $error("postproc map while unset");
    a_cam_dead: assert property (
        ws && regAccess.map == MAP_CAMERA |-> cameraAddr[7:1] != 7'h0)
        else $error("camera map while unset");
    a_strobe_pulse: assert property (ws |=> !ws [*8])
        else $error("write strobe too long");
    a_map_hold: assert property (
        pageWr |=> $stable(regAccess.map) [*8])
        else $error("map moved inside a transfer");
    cover property (ws && regAccess.map == MAP_INTR);
    cover property (ws && regAccess.map == MAP_POSTPROC);
    cover property (ws && regAccess.map == MAP_CAMERA);
    cover property (regAccess.readStrobe && regAccess.map == MAP_USER);
endmodule : map_paging_chk
bind register_map_paging_decoder map_paging_chk u_chk (.mclk(mclk),
    .nrst(nrst), .regAccess(regAccess),
    .sub_map_page_field(sub_map_page_field),
    .postprocAddr(postprocAddr), .cameraAddr(cameraAddr));

// file: testbench/two_wire_master_model.sv
`timescale 1ns/1ps
module two_wire_master_model (
    input  wire logic mclk,
    input  wire logic sdaLine,
    output logic      sclPin,
    output logic      sdaDrv
);
    // released lines idle high through the pull-up
    initial begin
        sclPin = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wt
    task automatic startC();
        sdaDrv = 1'b0;
        wt(6);
        sclPin = 1'b0;
        wt(4);
    endtask : startC
    task automatic stopC();
        sdaDrv = 1'b0;
        wt(4);
        sclPin = 1'b1;
        wt(6);
        sdaDrv = 1'b1;
        wt(6);
    endtask : stopC
    // low phase of 8 cycles leaves room for the 2-flop synchronisers
    task automatic bitx(input logic b, output logic s);
        sdaDrv = b;
        wt(4);
        sclPin = 1'b1;
        wt(4);
        s = sdaLine;
        wt(4);
        sclPin = 1'b0;
        wt(4);
    endtask : bitx
    task automatic wrByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(d[i], s);
        bitx(1'b1, s);
        ack = ~s;
    endtask : wrByte
    task automatic rdByte(output logic [7:0] d, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(nack, s);
    endtask : rdByte
endmodule : two_wire_master_model

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import map_paging_pkg::*;
    logic        mclk;
    logic        nrst;
    logic        pinSel;
    logic        known;
    logic        ack;
    logic        sclPin;
    logic        sdaDrv;
    logic        sdaOe;
    logic        sdaOut;
    logic [1:0]  page;
    logic [7:0]  postAddr;
    logic [7:0]  camAddr;
    logic [7:0]  got;
    logic [7:0]  lastSub;
    logic [7:0]  lastData;
    reg_access_s acc;
    map_e        lastMap;
    int          fails;
    int          num_checks;
    int          rdCnt = 0;
    // open drain with pull-up: low when the master drives 0 or the decoder is enabled and driving 0
    wire logic   sdaLine = sdaDrv & (~sdaOe | sdaOut);
    two_wire_master_model u_master (.mclk(mclk), .sdaLine(sdaLine),
        .sclPin(sclPin), .sdaDrv(sdaDrv));
    register_map_paging_decoder u_register_map_paging_decoder (
        .mclk(mclk), .nrst(nrst), .sclIn(sclPin), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .address_select_pin(pinSel),
        .regAccess(acc), .regRdata(acc.subaddr ^ 8'h5a),
        .subaddrKnown(known), .sub_map_page_field(page),
        .postprocAddr(postAddr), .cameraAddr(camAddr));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (acc.writeStrobe === 1'b1) begin
            lastMap  <= acc.map;
            lastSub  <= acc.subaddr;
            lastData <= acc.wdata;
        end
        if (acc.readStrobe === 1'b1) rdCnt <= rdCnt + 1;
    end
    task automatic chk(input string n, input logic [7:0] e, g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tx(input logic [7:0] b, input logic e);
        u_master.wrByte(b, ack);
        chk("ack", {7'h0, e}, {7'h0, ack});
    endtask : tx
    task automatic probe(input logic [7:0] a, input logic e);
        u_master.startC();
        tx(a, e);
        u_master.stopC();
    endtask : probe
    task automatic wreg(input logic [7:0] a, s, d);
        u_master.startC();
        tx(a, 1'b1);
        tx(s, 1'b1);
        tx(d, 1'b1);
        u_master.stopC();
    endtask : wreg
    task automatic t_addr();
        for (int p = 0; p < 2; p++) begin
            pinSel = p[0];
            u_master.wt(4);
            probe(8'h40, ~p[0]);
            probe(8'h42, p[0]);
        end
        pinSel = 1'b0;
    endtask : t_addr
    task automatic t_pages();
        logic [7:0] code[3] = '{8'h20, 8'h40, 8'h00};
        map_e       want[3] = '{MAP_INTR, MAP_USER2, MAP_USER};
        for (int i = 0; i < 3; i++) begin
            wreg(8'h40, 8'h0e, code[i]);
            wreg(8'h40, 8'h10, 8'h33);
            chk("map", 8'(want[i]), 8'(lastMap));
            chk("data", 8'h33, lastData);
        end
        u_master.startC();
        tx(8'h40, 1'b1);
        tx(8'h0e, 1'b1);
        tx(8'h20, 1'b1);
        tx(8'h55, 1'b1);
        u_master.stopC();
        chk("map", 8'(MAP_USER), 8'(lastMap));
        chk("sub", 8'h0f, lastSub);
        chk("data", 8'h55, lastData);
        chk("page", 8'h01, {6'h0, page});
        wreg(8'h40, 8'h0e, 8'h00);
    endtask : t_pages
    task automatic t_maps();
        probe(8'h84, 1'b0);
        probe(8'h88, 1'b0);
        wreg(8'h40, 8'hfd, 8'h84);
        wreg(8'h40, 8'hfe, 8'h88);
        chk("post", 8'h84, postAddr);
        chk("cam", 8'h88, camAddr);
        pinSel = 1'b1;
        wreg(8'h42, 8'h0e, 8'h20);
        wreg(8'h84, 8'h05, 8'h11);
        chk("map", 8'(MAP_POSTPROC), 8'(lastMap));
        wreg(8'h88, 8'h07, 8'h22);
        chk("map", 8'(MAP_CAMERA), 8'(lastMap));
        wreg(8'h42, 8'h0e, 8'h00);
        pinSel = 1'b0;
    endtask : t_maps
    task automatic t_misc();
        known = 1'b0;
        u_master.startC();
        tx(8'h40, 1'b1);
        tx(8'h10, 1'b0);
        u_master.stopC();
        known = 1'b1;
        probe(8'h40, 1'b1);
        u_master.startC();
        tx(8'h40, 1'b1);
        tx(8'hfd, 1'b1);
        u_master.stopC();
        u_master.startC();
        tx(8'h41, 1'b1);
        u_master.rdByte(got, 1'b0);
        chk("rd", 8'h84, got);
        u_master.rdByte(got, 1'b0);
        chk("rd", 8'h88, got);
        // map contents model returns subaddress xor 5a; top one repeats
        u_master.rdByte(got, 1'b0);
        chk("rd", 8'ha5, got);
        u_master.rdByte(got, 1'b1);
        chk("rd", 8'ha5, got);
        chk("rdstb", 8'h04, 8'(rdCnt));
        u_master.stopC();
    endtask : t_misc
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (100000) @(posedge mclk);
        fails++;
        final_report();
    end
    initial begin
        nrst = 1'b0;
        pinSel = 1'b0;
        known = 1'b1;
        fails = 0;
        num_checks = 0;
        repeat (12) @(posedge mclk);
        #1;
        nrst = 1'b1;
        u_master.wt(3);
        chk("page", 8'h00, {6'h0, page});
        chk("post", 8'h00, postAddr);
        chk("cam", 8'h00, camAddr);
        t_addr();
        t_pages();
        t_maps();
        t_misc();
        final_report();
    end
endmodule : testbench
